//--- hw/utx_port.sv
// transmit half of an asynchronous serial port with modem status and loopback
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
// Overview of operation
// - frame is start, data, parity, stop bits
// - break waits for character end, holds line low
// - leaving break resumes fifo, contents untouched
// - data writes queue, frames sent until empty
// - busy covers queued data and shifting frame
// - fifo mode tx irq while eight free
// - single mode tx irq while holder empty
// - enabled and empty drives mark, empty flag
// - full flag follows fifo full state
// - receive error flags replaced per character
// - standby and idle force inactive outputs
// - infrared mode holds wired output high
// - modem inputs shown on second, third ports
// - modem input change sets raw modem irq
// - raw status write clears only modem irq
// - masked status is raw and enable
// - combined irq ors masked sources
// - loopback routes outputs to receive inputs
// - blank disable turns receiver blanking off
// - tx invert selects active low data
// - word length selects five to eight bits
// - even select chooses parity sense
// - infrared pulse lasts three sixteenths bit
module utx_port #(
   parameter bit FIRST_PORT = 1'b0,
   parameter int DEPTH = utx_pkg::FIFO_DEPTH,
   parameter int AW = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rd_data_o,
   input wire logic standby_i,
   input wire logic idle_i,
   input wire logic dcd_i,
   input wire logic dsr_i,
   input wire logic cts_i,
   input wire logic wired_serial_in_i,
   input wire logic infrared_serial_in_i,
   input wire logic rx_char_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic [3:0] rx_err_i,
   input wire logic rx_irq_flag_i,
   input wire logic rx_idle_timeout_irq_i,
   output logic wired_serial_out_o,
   output logic infrared_serial_out_o,
   output logic rx_wired_o,
   output logic rx_ir_o,
   output logic rx_pop_o,
   output logic busy_o,
   output logic combined_port_irq_o
);
   import utx_pkg::*;

   logic [FR_WIDTH-1:0] frame_fifo_control;
   logic [CT_WIDTH-1:0] ctrl;
   logic [15:0] baud_div;
   logic [3:0] irq_enable_mask;
   logic modem_change_irq;
   logic tx_fifo_empty_flag;
   logic [7:0] rx_data;
   logic [3:0] rx_err;
   logic [7:0] fifo_mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [2:0] modem_meta;
   logic [2:0] modem_sync;
   logic [2:0] modem_prev;
   logic [1:0] rx_meta;
   logic [1:0] rx_sync;
   logic [15:0] baud_cnt;
   logic [3:0] sub_cnt;
   logic [2:0] bit_cnt;
   logic stop_cnt;
   logic [7:0] shifter;
   logic par_bit;
   utx_state_e state;
   utx_state_e next_state;

   // field views
   wire break_request = frame_fifo_control[FR_BREAK];
   wire parity_enable = frame_fifo_control[FR_PARITY];
   wire even_parity_select = frame_fifo_control[FR_EVEN];
   wire two_stop_select = frame_fifo_control[FR_STOP2];
   wire fifo_enable = frame_fifo_control[FR_FIFO_EN];
   wire [1:0] word_length = frame_fifo_control[FR_WORD_LENGTH_LO +: 2];
   wire port_enable = ctrl[CT_ENABLE];
   wire ir_mode_off = ctrl[CT_IR_OFF];
   wire tx_invert = ctrl[CT_TX_INV];
   wire loopback_select = ctrl[CT_LOOP];
   wire ir_blank_disable = ctrl[CT_BLANK_DIS];
   wire ir_active = FIRST_PORT && !ir_mode_off;

   // bus decode
   wire wr_data = wr_i && (addr_i == ADDR_DATA);
   wire wr_frame = wr_i && (addr_i == ADDR_FRAME);
   wire wr_baud = wr_i && (addr_i == ADDR_BAUD);
   wire wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
   wire wr_raw = wr_i && (addr_i == ADDR_RAW);
   wire wr_mask = wr_i && (addr_i == ADDR_MASK);
   wire rd_data = rd_i && (addr_i == ADDR_DATA);

   // fifo with a single holding location when fifo mode is off
   wire [AW:0] capacity = fifo_enable ? (AW+1)'(DEPTH) : (AW+1)'(1);
   wire fifo_full = (count >= capacity);
   wire fifo_empty = (count == '0);
   wire push = wr_data && !fifo_full;
   wire load = (state == UTX_IDLE) && port_enable && !fifo_empty && !break_request;
   wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(load);

   // baud generation, gated while the port is disabled
   wire tick = port_enable && (baud_cnt == baud_div);
   wire bit_end = tick && (sub_cnt == 4'(OVERSAMPLE - 1));
   wire [2:0] last_bit = {1'b1, word_length};

   function automatic logic [7:0] utx_mask_data(input logic [7:0] d, input logic [1:0] wl);
      logic [7:0] m;
      m = 8'hff >> (2'h3 - wl);
      return d & m;
   endfunction : utx_mask_data

   wire [7:0] load_data = utx_mask_data(fifo_mem[rd_ptr], word_length);
   wire load_par = even_parity_select ? ^load_data : ~^load_data;

   always_comb begin
      next_state = state;
      unique case (state)
         UTX_IDLE: begin
            if (break_request && port_enable) begin
               next_state = UTX_BREAK;
            end else if (load) begin
               next_state = UTX_START;
            end
         end
         UTX_START: begin
            if (bit_end) begin
               next_state = UTX_DATA;
            end
         end
         UTX_DATA: begin
            if (bit_end && (bit_cnt == last_bit)) begin
               next_state = parity_enable ? UTX_PARITY : UTX_STOP;
            end
         end
         UTX_PARITY: begin
            if (bit_end) begin
               next_state = UTX_STOP;
            end
         end
         UTX_STOP: begin
            if (bit_end && (stop_cnt || !two_stop_select)) begin
               next_state = UTX_IDLE;
            end
         end
         UTX_BREAK: begin
            if (!break_request) begin
               next_state = UTX_IDLE;
            end
         end
      endcase
   end

   // logical value of the bit on the line, 1 is mark
   logic line_bit;
   always_comb begin
      line_bit = 1'b1;
      unique case (state)
         UTX_IDLE: line_bit = 1'b1;
         UTX_START: line_bit = 1'b0;
         UTX_DATA: line_bit = shifter[0];
         UTX_PARITY: line_bit = par_bit;
         UTX_STOP: line_bit = 1'b1;
         UTX_BREAK: line_bit = 1'b0;
      endcase
   end

   wire low_power = standby_i || idle_i;
   // ir pulse only marks zero bits, never during break hold
   wire ir_pulse = !line_bit && (state != UTX_BREAK) && (sub_cnt < 4'(IR_PULSE_TICKS));
   wire next_wired = low_power ? ~tx_invert :
                     ir_active ? 1'b1 :
                     (line_bit ^ tx_invert);
   wire next_ir = low_power ? tx_invert :
                  ir_active ? (ir_pulse ^ tx_invert) : tx_invert;

   // blanking hides our own ir echo from the receiver while sending
   wire blank = ir_active && !ir_blank_disable && (state != UTX_IDLE);
   wire next_rx_wired = loopback_select ? wired_serial_out_o : rx_sync[0];
   wire next_rx_ir = blank ? 1'b0 :
                     loopback_select ? infrared_serial_out_o : rx_sync[1];

   // interrupts
   wire [AW:0] free = capacity - count;
   wire tx_irq_flag = fifo_enable ? (free >= (AW+1)'(TX_IRQ_FREE)) : fifo_empty;
   wire modem_change = !FIRST_PORT && (modem_sync != modem_prev);
   wire [3:0] raw_irq_status = {rx_idle_timeout_irq_i, modem_change_irq && !FIRST_PORT,
                                tx_irq_flag, rx_irq_flag_i};
   wire [3:0] masked_irq_status = raw_irq_status & irq_enable_mask;
   wire [3:0] status = {1'b0, !FIRST_PORT && modem_sync[2], !FIRST_PORT && modem_sync[1],
                        !FIRST_PORT && modem_sync[0]};
   wire next_busy = !fifo_empty || ((state != UTX_IDLE) && (state != UTX_BREAK));

   logic [31:0] next_rd_data;
   always_comb begin
      next_rd_data = 32'h0;
      unique case (addr_i)
         ADDR_DATA: next_rd_data = {20'h0, rx_err, rx_data};
         ADDR_FRAME: next_rd_data = {25'h0, frame_fifo_control};
         ADDR_BAUD: next_rd_data = {16'h0, baud_div};
         ADDR_CTRL: next_rd_data = {24'h0, ctrl};
         ADDR_STATUS: begin
            next_rd_data[ST_CTS] = status[0];
            next_rd_data[ST_DSR] = status[1];
            next_rd_data[ST_DCD] = status[2];
            next_rd_data[ST_BUSY] = busy_o;
            next_rd_data[ST_TX_FULL] = fifo_full;
            next_rd_data[ST_TX_EMPTY] = tx_fifo_empty_flag;
         end
         ADDR_RAW: next_rd_data = {28'h0, raw_irq_status};
         ADDR_MASK: next_rd_data = {28'h0, irq_enable_mask};
         ADDR_MASKED: next_rd_data = {28'h0, masked_irq_status};
         default: next_rd_data = 32'h0;
      endcase
      if (!rd_i) begin
         next_rd_data = 32'h0;
      end
   end

   // registers written by software
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         frame_fifo_control <= FR_RESET;
         ctrl <= CT_RESET;
         baud_div <= BAUD_RESET;
         irq_enable_mask <= MASK_RESET;
      end else begin
         if (wr_frame) frame_fifo_control <= wr_data_i[FR_WIDTH-1:0];
         if (wr_ctrl) ctrl <= wr_data_i[CT_WIDTH-1:0];
         if (wr_baud) baud_div <= wr_data_i[15:0];
         if (wr_mask) irq_enable_mask <= wr_data_i[3:0];
      end
   end

   // fifo storage has no reset; only the pointers and count need one
   always_ff @(posedge clk_i) begin
      if (push) fifo_mem[wr_ptr] <= wr_data_i[7:0];
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         // break never touches pointers, so queued data survives it
         if (push) wr_ptr <= wr_ptr + AW'(1);
         if (load) rd_ptr <= rd_ptr + AW'(1);
         count <= next_count;
      end
   end

   // set by an empty queue while the port is enabled, cleared by a data write
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_fifo_empty_flag <= 1'b1;
      end else if (wr_data) begin
         tx_fifo_empty_flag <= 1'b0;
      end else if (port_enable && (next_count == '0)) begin
         tx_fifo_empty_flag <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         baud_cnt <= '0;
         sub_cnt <= '0;
      end else if (load || (state == UTX_IDLE)) begin
         baud_cnt <= '0;
         sub_cnt <= '0;
      end else if (tick) begin
         baud_cnt <= '0;
         sub_cnt <= sub_cnt + 4'h1;
      end else if (port_enable) begin
         baud_cnt <= baud_cnt + 16'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= UTX_IDLE;
         shifter <= '0;
         par_bit <= 1'b0;
         bit_cnt <= '0;
         stop_cnt <= 1'b0;
      end else begin
         state <= next_state;
         if (load) begin
            shifter <= load_data;
            par_bit <= load_par;
            bit_cnt <= '0;
            stop_cnt <= 1'b0;
         end else if (bit_end && (state == UTX_DATA)) begin
            shifter <= {1'b0, shifter[7:1]};
            bit_cnt <= bit_cnt + 3'h1;
         end else if (bit_end && (state == UTX_STOP)) begin
            stop_cnt <= 1'b1;
         end
      end
   end

   // receive character latch: errors change only when a new character lands
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_data <= '0;
         rx_err <= '0;
      end else if (rx_char_valid_i) begin
         rx_data <= rx_data_i;
         rx_err <= rx_err_i;
      end
   end

   // pins pass two flops; only the second stage, and for modem pins its delayed copy modem_prev, is looked at
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         modem_meta <= '0;
         modem_sync <= '0;
         modem_prev <= '0;
         rx_meta <= 2'h3;
         rx_sync <= 2'h3;
      end else begin
         modem_meta <= {dcd_i, dsr_i, cts_i};
         modem_sync <= modem_meta;
         modem_prev <= modem_sync;
         rx_meta <= {infrared_serial_in_i, wired_serial_in_i};
         rx_sync <= rx_meta;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         modem_change_irq <= 1'b0;
      end else if (modem_change) begin
         modem_change_irq <= 1'b1;
      end else if (wr_raw) begin
         modem_change_irq <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_data_o <= '0;
         rx_pop_o <= 1'b0;
         wired_serial_out_o <= 1'b1;
         infrared_serial_out_o <= 1'b0;
         rx_wired_o <= 1'b1;
         rx_ir_o <= 1'b0;
         busy_o <= 1'b0;
         combined_port_irq_o <= 1'b0;
      end else begin
         rd_data_o <= next_rd_data;
         rx_pop_o <= rd_data;
         wired_serial_out_o <= next_wired;
         infrared_serial_out_o <= next_ir;
         rx_wired_o <= next_rx_wired;
         rx_ir_o <= next_rx_ir;
         busy_o <= next_busy;
         combined_port_irq_o <= |masked_irq_status;
      end
   end
endmodule : utx_port

//--- hw/utx_pkg.sv
// constants shared by the serial transmit port
package utx_pkg;
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_FRAME = 8'h04;
   localparam logic [7:0] ADDR_BAUD = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_RAW = 8'h14;
   localparam logic [7:0] ADDR_MASK = 8'h18;
   localparam logic [7:0] ADDR_MASKED = 8'h1c;
   // frame_fifo_control fields
   localparam int FR_BREAK = 0;
   localparam int FR_PARITY = 1;
   localparam int FR_EVEN = 2;
   localparam int FR_STOP2 = 3;
   localparam int FR_FIFO_EN = 4;
   localparam int FR_WORD_LENGTH_LO = 5;
   localparam int FR_WIDTH = 7;
   localparam logic [6:0] FR_RESET = 7'h00;
   // control fields
   localparam int CT_ENABLE = 0;
   localparam int CT_IR_OFF = 1;
   localparam int CT_TX_INV = 4;
   localparam int CT_LOOP = 6;
   localparam int CT_BLANK_DIS = 7;
   localparam int CT_WIDTH = 8;
   localparam logic [7:0] CT_RESET = 8'h00;
   // status fields
   localparam int ST_CTS = 0;
   localparam int ST_DSR = 1;
   localparam int ST_DCD = 2;
   localparam int ST_BUSY = 3;
   localparam int ST_TX_FULL = 5;
   localparam int ST_TX_EMPTY = 7;
   // interrupt fields, same layout in raw, mask and masked
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;
   localparam int IRQ_MODEM = 2;
   localparam int IRQ_TIMEOUT = 3;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [15:0] BAUD_RESET = 16'h0000;
   // timing in baud ticks, then fifo depth and tx irq free threshold in entries
   localparam int OVERSAMPLE = 16;
   localparam int IR_PULSE_TICKS = 3;
   localparam int FIFO_DEPTH = 16;
   localparam int TX_IRQ_FREE = 8;
   typedef enum logic [2:0] {
      UTX_IDLE = 3'b000,
      UTX_START = 3'b001,
      UTX_DATA = 3'b011,
      UTX_PARITY = 3'b010,
      UTX_STOP = 3'b110,
      UTX_BREAK = 3'b111
   } utx_state_e;
endpackage : utx_pkg

//--- tb/utx_port_monitor.sv
// assertions watching the serial transmit port pins
`timescale 1ns/100ps
module utx_port_monitor
   import utx_pkg::*;
#(
   parameter bit FIRST_PORT = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rd_data_o,
   input wire logic standby_i,
   input wire logic idle_i,
   input wire logic wired_serial_out_o,
   input wire logic infrared_serial_out_o,
   input wire logic rx_wired_o,
   input wire logic rx_pop_o,
   input wire logic busy_o,
   input wire logic combined_port_irq_o
);
   logic [6:0] frame_q;
   logic [7:0] ctrl_q;
   logic [3:0] mask_q;
   logic [1:0] calm;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         frame_q <= FR_RESET;
         ctrl_q <= CT_RESET;
         mask_q <= MASK_RESET;
      end else if (wr_i) begin
         if (addr_i == ADDR_FRAME) frame_q <= wr_data_i[6:0];
         if (addr_i == ADDR_CTRL) ctrl_q <= wr_data_i[7:0];
         if (addr_i == ADDR_MASK) mask_q <= wr_data_i[3:0];
      end
   end
   // any write restarts the settle count: fewer checks, but no pipeline races
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || wr_i || busy_o || standby_i || idle_i) calm <= 2'h0;
      else if (calm != 2'h3) calm <= calm + 2'h1;
   end
   chk_low_power_rest: assert property (
      (standby_i || idle_i) |=> wired_serial_out_o != infrared_serial_out_o)
      else $error("low power outputs not at rest");
   chk_busy_on_write: assert property (
      wr_i && addr_i == ADDR_DATA |-> ##[1:2] busy_o) else $error("busy missed a write");
   chk_busy_min_bit: assert property (
      $rose(busy_o) |=> busy_o [*8]) else $error("busy dropped inside a bit");
   chk_idle_line_level: assert property (
      calm == 2'h3 && ctrl_q[CT_ENABLE] && (!FIRST_PORT || ctrl_q[CT_IR_OFF]) |->
      wired_serial_out_o == (frame_q[FR_BREAK] ~^ ctrl_q[CT_TX_INV]))
      else $error("idle or break line level wrong");
   chk_loop_wired: assert property (
      ctrl_q[CT_LOOP] && $past(ctrl_q[CT_LOOP]) |-> rx_wired_o == $past(wired_serial_out_o))
      else $error("loopback path broken");
   chk_masked_subset: assert property (
      rd_i && addr_i == ADDR_MASKED |=> (rd_data_o & ~{28'h0, mask_q}) == 32'h0)
      else $error("masked status outside enables");
   chk_irq_all_masked: assert property (
      mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !combined_port_irq_o)
      else $error("irq with all sources masked");
   chk_pop_after_read: assert property (
      rd_i && addr_i == ADDR_DATA |=> rx_pop_o) else $error("no pop after data read");
   cov_break_line: cover property (calm == 2'h3 && frame_q[FR_BREAK]);
   cov_busy_end: cover property ($fell(busy_o));
   cov_loop_low: cover property (ctrl_q[CT_LOOP] && !rx_wired_o);
   cov_irq: cover property (combined_port_irq_o);
endmodule : utx_port_monitor
bind utx_port utx_port_monitor #(.FIRST_PORT(FIRST_PORT)) i_mon (.clk_i, .rst_n_i, .addr_i,
   .wr_data_i, .wr_i, .rd_i, .rd_data_o, .standby_i, .idle_i, .wired_serial_out_o,
   .infrared_serial_out_o, .rx_wired_o, .rx_pop_o, .busy_o, .combined_port_irq_o);

//--- tb/utx_line_peer.sv
// remote serial receiver decoding frames off the transmit line
`timescale 1ns/100ps
module utx_line_peer #(
   parameter int BIT = 16
) (
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic inv_i,
   input wire logic [3:0] nbits_i,
   input wire logic par_en_i,
   output logic [7:0] data_o,
   output logic par_o,
   output logic stop_o,
   output int got_o,
   output int span_o
);
   int cyc = 0;
   int last = 0;
   logic prev = 1'b1;
   always @(posedge clk_i) cyc <= cyc + 1;
   // only a fall from mark starts a frame, so a held break counts once
   initial begin
      got_o = 0;
      span_o = 0;
      forever begin
         @(posedge clk_i);
         if (prev && !(line_i ^ inv_i)) begin
            span_o = cyc - last;
            last = cyc;
            repeat (BIT / 2) @(posedge clk_i);
            data_o = 8'h00;
            for (int i = 0; i < nbits_i; i++) begin
               repeat (BIT) @(posedge clk_i);
               data_o[i] = line_i ^ inv_i;
            end
            if (par_en_i) begin
               repeat (BIT) @(posedge clk_i);
               par_o = line_i ^ inv_i;
            end
            repeat (BIT) @(posedge clk_i);
            stop_o = line_i ^ inv_i;
            got_o++;
         end
         prev = line_i ^ inv_i;
      end
   end
endmodule : utx_line_peer

//--- tb/utx_port_bench.sv
// self-checking bench for the serial transmit port
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %0t: got %0h want %0h", $time, g, e); end end
module utx_port_bench;
   import utx_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic standby_i = 1'b0;
   logic idle_i = 1'b0;
   logic [2:0] modem = 3'h0;
   logic wsin = 1'b1;
   logic rxv = 1'b0;
   logic [7:0] rxd = 8'h00;
   logic [3:0] rxe = 4'h0;
   logic [1:0] rxq = 2'h0;
   logic inv = 1'b0;
   logic par_en = 1'b0;
   logic [3:0] nbits = 4'h8;
   logic [31:0] rd_data_o;
   logic wired_serial_out_o, infrared_serial_out_o, rx_wired_o, rx_pop_o, busy_o, irq;
   logic rx_ir, ir_wired, ir_out, ir_rx;
   logic [31:0] ir_rd;
   logic [7:0] pdata, d;
   logic ppar, pstop;
   logic [31:0] v;
   int got, span, b, h;
   int ir_run = 0;
   int ir_len = 0;
   int ir_hits = 0;
   int n_mismatch = 0;
   int cmp_count = 0;
   always #2.5 clk_i = ~clk_i;
   utx_port i_dut (.clk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .standby_i,
      .idle_i, .dcd_i(modem[2]), .dsr_i(modem[1]), .cts_i(modem[0]), .wired_serial_in_i(wsin),
      .infrared_serial_in_i(!wsin), .rx_char_valid_i(rxv), .rx_data_i(rxd), .rx_err_i(rxe),
      .rx_irq_flag_i(rxq[0]), .rx_idle_timeout_irq_i(rxq[1]), .wired_serial_out_o,
      .infrared_serial_out_o, .rx_wired_o, .rx_ir_o(rx_ir), .rx_pop_o, .busy_o,
      .combined_port_irq_o(irq));
   utx_line_peer i_peer (.clk_i, .line_i(wired_serial_out_o), .inv_i(inv), .nbits_i(nbits),
      .par_en_i(par_en), .data_o(pdata), .par_o(ppar), .stop_o(pstop), .got_o(got),
      .span_o(span));
   // first-port flavour shares the bus so its infrared path runs in step with i_dut
   utx_port #(.FIRST_PORT(1'b1)) i_ir (.clk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
      .rd_data_o(ir_rd), .standby_i, .idle_i, .dcd_i(modem[2]), .dsr_i(modem[1]),
      .cts_i(modem[0]), .wired_serial_in_i(wsin), .infrared_serial_in_i(1'b0),
      .rx_char_valid_i(rxv), .rx_data_i(rxd), .rx_err_i(rxe), .rx_irq_flag_i(rxq[0]),
      .rx_idle_timeout_irq_i(rxq[1]), .wired_serial_out_o(ir_wired),
      .infrared_serial_out_o(ir_out), .rx_wired_o(), .rx_ir_o(ir_rx), .rx_pop_o(), .busy_o(),
      .combined_port_irq_o());
   // width of the latest ir pulse, and how often the looped ir input was seen high
   always @(posedge clk_i) begin
      ir_run <= ir_out ? ir_run + 1 : 0;
      if (!ir_out && ir_run != 0) ir_len <= ir_run;
      if (ir_rx) ir_hits <= ir_hits + 1;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= x;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] x);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 x = rd_data_o;
   endtask : rd
   task automatic wait_got(input int n);
      for (int i = 0; i < 4000 && got < n; i++) @(posedge clk_i);
      `CHK(got >= n, 1'b1)
   endtask : wait_got
   // let line settle after a level change, then take the frame count
   task automatic settle;
      repeat (250) @(posedge clk_i);
      b = got;
   endtask : settle
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(ADDR_CTRL, v);
      `CHK(v, 32'h0)
      wr(8'h20, 32'hff);
      rd(8'h20, v);
      `CHK(v, 32'h0)
      wr(ADDR_MASK, 32'h0);
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_STATUS, v);
      `CHK(v[ST_TX_EMPTY], 1'b1)
      for (int w = 0; w < 4; w++) begin
         for (int p = 0; p < 4; p += (p == 0) ? 1 : 2) begin
            repeat (40) @(posedge clk_i);
            wr(ADDR_CTRL, w[0] ? 32'h11 : 32'h01);
            wr(ADDR_FRAME, 32'((w << FR_WORD_LENGTH_LO) | (p << FR_PARITY)));
            inv <= w[0];
            par_en <= p[0];
            nbits <= 4'(5 + w);
            settle();
            d = 8'h9c + 8'(w * 29 + p);
            wr(ADDR_DATA, {24'h0, d});
            wait_got(b + 1);
            `CHK(pdata, d & (8'hff >> (3 - w)))
            if (p != 0) `CHK(ppar, ^(d & (8'hff >> (3 - w))) ~^ p[1])
            `CHK(pstop, 1'b1)
         end
      end
      $display("test framing done");
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_FRAME, 32'h78);
      inv <= 1'b0;
      par_en <= 1'b0;
      nbits <= 4'h8;
      settle();
      for (int i = 0; i < 3; i++) wr(ADDR_DATA, 32'h31 + 32'(i));
      for (int i = 0; i < 3; i++) begin
         wait_got(b + i + 1);
         `CHK(pdata, 8'h31 + 8'(i))
         if (i > 0) `CHK(span, 11 * OVERSAMPLE + 1)
      end
      `CHK(ir_len, IR_PULSE_TICKS)
      repeat (40) @(posedge clk_i);
      `CHK(busy_o, 1'b0)
      $display("test stop bits done");
      wr(ADDR_FRAME, 32'h70);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_MASK, 32'h2);
      for (int i = 1; i <= 17; i++) begin
         wr(ADDR_DATA, 32'(i));
         rd(ADDR_RAW, v);
         `CHK(v[IRQ_TX], FIFO_DEPTH - i >= TX_IRQ_FREE)
         rd(ADDR_STATUS, v);
         `CHK(v[ST_TX_FULL], i >= FIFO_DEPTH)
         `CHK(irq, FIFO_DEPTH - i >= TX_IRQ_FREE)
      end
      `CHK(busy_o, 1'b1)
      b = got;
      wr(ADDR_CTRL, 32'h1);
      wait_got(b + 1);
      rd(ADDR_STATUS, v);
      `CHK(v[ST_TX_FULL], 1'b0)
      wait_got(b + 16);
      `CHK(pdata, 8'h10)
      repeat (400) @(posedge clk_i);
      `CHK(got, b + 16)
      wr(ADDR_MASK, 32'h0);
      $display("test fifo done");
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_FRAME, 32'h60);
      rd(ADDR_RAW, v);
      `CHK(v[IRQ_TX], 1'b1)
      wr(ADDR_DATA, 32'h77);
      rd(ADDR_RAW, v);
      `CHK(v[IRQ_TX], 1'b0)
      rd(ADDR_STATUS, v);
      `CHK(v[ST_TX_EMPTY], 1'b0)
      b = got;
      wr(ADDR_CTRL, 32'h1);
      wait_got(b + 1);
      `CHK(pdata, 8'h77)
      rd(ADDR_RAW, v);
      `CHK(v[IRQ_TX], 1'b1)
      $display("test single holder done");
      wr(ADDR_FRAME, 32'h70);
      b = got;
      wr(ADDR_DATA, 32'h96);
      wr(ADDR_FRAME, 32'h71);
      wait_got(b + 1);
      `CHK(pdata, 8'h96)
      wr(ADDR_DATA, 32'h69);
      for (int k = 0; k < 6; k++) begin
         repeat (100) @(posedge clk_i);
         `CHK(wired_serial_out_o, 1'b0)
         `CHK(ir_wired, 1'b1)
      end
      wr(ADDR_FRAME, 32'h70);
      wait_got(b + 3);
      `CHK(pdata, 8'h69)
      `CHK(pstop, 1'b1)
      $display("test break done");
      for (int k = 0; k < 4; k++) begin
         standby_i <= !k[1];
         idle_i <= k[1];
         wr(ADDR_CTRL, k[0] ? 32'h11 : 32'h01);
         repeat (3) @(posedge clk_i);
         `CHK(wired_serial_out_o, !k[0])
         `CHK(infrared_serial_out_o, k[0])
      end
      standby_i <= 1'b0;
      idle_i <= 1'b0;
      wr(ADDR_CTRL, 32'h1);
      $display("test low power done");
      for (int m = 1; m < 8; m++) begin
         modem <= 3'(m);
         repeat (5) @(posedge clk_i);
         rd(ADDR_STATUS, v);
         `CHK(v[2:0], 3'(m))
         `CHK(ir_rd[2:0], 3'h0)
         rd(ADDR_RAW, v);
         `CHK(v[IRQ_MODEM], 1'b1)
         wr(ADDR_RAW, 32'h0);
         rd(ADDR_RAW, v);
         `CHK(v[IRQ_TX] & !v[IRQ_MODEM], 1'b1)
      end
      rxq <= 2'h3;
      modem <= 3'h0;
      repeat (5) @(posedge clk_i);
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_MASK, 32'h1 << s);
         repeat (3) @(posedge clk_i);
         `CHK(irq, 1'b1)
         rd(ADDR_MASKED, v);
         `CHK(v, 32'h1 << s)
      end
      wr(ADDR_MASK, 32'h0);
      rxq <= 2'h0;
      $display("test interrupts done");
      rxv <= 1'b1;
      rxd <= 8'h3c;
      rxe <= 4'h5;
      @(posedge clk_i);
      rxv <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         rd(ADDR_DATA, v);
         `CHK(v, 32'h53c)
      end
      $display("test receive flags done");
      wsin <= 1'b0;
      wr(ADDR_CTRL, 32'h41);
      settle();
      `CHK(rx_wired_o, 1'b1)
      `CHK(rx_ir, 1'b0)
      h = ir_hits;
      wr(ADDR_DATA, 32'h0f);
      wait_got(b + 1);
      `CHK(pdata, 8'h0f)
      `CHK(ir_hits, h)
      wr(ADDR_CTRL, 32'hc1);
      wr(ADDR_DATA, 32'h0f);
      wait_got(b + 2);
      `CHK(ir_hits > h, 1'b1)
      repeat (40) @(posedge clk_i);
      wr(ADDR_CTRL, 32'h1);
      repeat (5) @(posedge clk_i);
      `CHK(rx_wired_o, 1'b0)
      `CHK(rx_ir, 1'b1)
      $display("test loopback done");
      give_verdict();
   end
endmodule : utx_port_bench
